/* File: rtl/tlb_cache_test_access.v */
// Functional notes
// R1 - translation buffer: four ways of eight entries, 20-bit tag, 20-bit page
// R2 - control bit 0 picks the operation: 0 writes, 1 looks up
// R3 - a write allocates an entry for control page and stores data page
// R4 - lookup by control page; only a single match updates the fields
// R5 - on write, control bit 11 validates or invalidates the target entry
// R6 - control holds dirty, user and read/write pairs at 10-9, 8-7, 6-5
// R7 - lookup pair 00 never, 01 stored 0, 10 stored 1, 11 any
// R8 - write pair 01 clears, 10 sets the stored attribute
// R9 - data bits 11 and 10 hold cache-disable and write-through
// R10 - lookup returns prior LRU state in data 9-7; write ignores it
// R11 - lookup sets data bit 4 on hit, clears it on miss
// R12 - write: flag 1 uses set-choice field, flag 0 uses pseudo-LRU; with flag 0 the code takes the lowest empty way first
// R13 - lookup hit reports the matching set in bits 3-2
// R14 - cache: 256 direct-mapped or two ways of 128, 23-bit tag
// R15 - one valid bit per byte, tag-status bits 6-3
// R16 - LRU bit marks last used set, read in bit 7, write ignores
// R17 - software sets valid bits before writing data to an entry
// R18 - cache write stores the data register; read loads it
// R19 - tag-status 31-9 holds the tag on read and write
// R20 - control 10-4 give entry address; direct-mapped bit 9 per op
// R21 - two-way: control bit 2 picks set 0 or set 1
// R22 - control 1-0: none, write, read, flush all entries
// R23 - writing a command-bearing control register starts the operation
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none
`include "tlb_cache_consts.vh"
module tlb_cache_test_access (
  // clock and reset
  input wire CLK_I,
  input wire RESETN_I,
  // wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:2] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output wire ACK_O,
  output reg [31:0] DAT_O
);

  // bus side
  reg ack_r;
  reg [31:0] rd_nxt;

  // software-visible test registers
  reg [31:0] tlb_ctl_r;
  reg [31:0] tlb_dat_r;

  reg [31:0] c_dat_r;
  reg [31:0] c_ts_r;
  reg [31:0] c_ctl_r;

  // cache organisation, direct-mapped out of reset
  reg two_way_r;

  // translation buffer storage, entry address {set, index} [R1]
  reg [19:0] tlb_lin [0:31];
  reg [19:0] tlb_phys [0:31];
  reg [4:0] tlb_attr [0:31]; // {d, u, w, pcd, pwt}
  reg [31:0] tlb_valid_r;
  // one pseudo-LRU tree per index, shared by the four ways
  reg [2:0] tlb_lru [0:7];

  // cache storage, 256 lines shared by both configurations [R14]
  reg [22:0] c_tag [0:255];
  reg [31:0] c_data [0:255];
  reg [3:0] c_val [0:255];
  reg [127:0] c_lru_r;

  // loop counter for the storage initialisation
  integer i;

  // byte-lane merge of a bus write into a register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // pair {bit, complement} against a stored attribute
  function attr_ok;
    input [1:0] pair;
    input stored;
    begin
      case (pair)
        2'h0: attr_ok = 1'b0;
        2'h1: attr_ok = ~stored;
        2'h2: attr_ok = stored;
        default: attr_ok = 1'b1;
      endcase
    end
  endfunction

  // tree bits {b2, b1, b0}: b0 high means pair 0/1 was last used
  function [2:0] plru_upd;
    input [2:0] old;
    input [1:0] s;
    begin
      // the tree points away from the way just used
      plru_upd = old;
      plru_upd[0] = ~s[1];
      if (s[1])
        plru_upd[2] = ~s[0];
      else
        plru_upd[1] = ~s[0];
    end
  endfunction

  function [1:0] plru_victim;
    input [2:0] t;
    begin
      // follow the tree away from the last used side
      plru_victim = t[0] ? {1'b1, t[2]} : {1'b0, t[1]};
    end
  endfunction

  // one bus cycle per access: taken on the first edge, ack the next
  wire req = CYC_I & STB_I & ~ack_r;
  wire wr = req & WE_I;
  assign ACK_O = ack_r;

  // register values as they stand after this cycle's bus write
  wire [31:0] tctl_w = (wr && ADR_I == `IDX_TLB_CTL) ?
    merge(tlb_ctl_r, DAT_I, SEL_I) : tlb_ctl_r;
  wire [31:0] tdat_w = (wr && ADR_I == `IDX_TLB_DAT) ?
    merge(tlb_dat_r, DAT_I, SEL_I) : tlb_dat_r;

  wire [31:0] cdat_w = (wr && ADR_I == `IDX_C_DAT) ?
    merge(c_dat_r, DAT_I, SEL_I) : c_dat_r;
  wire [31:0] cts_w = (wr && ADR_I == `IDX_C_TS) ?
    merge(c_ts_r, DAT_I, SEL_I) : c_ts_r;
  wire [31:0] cctl_w = (wr && ADR_I == `IDX_C_CTL) ?
    merge(c_ctl_r, DAT_I, SEL_I) : c_ctl_r;

  wire tlb_go = wr && ADR_I == `IDX_TLB_CTL; // [R23]
  wire c_go = wr && ADR_I == `IDX_C_CTL; // [R23]

  wire tlb_lookup = tctl_w[`TC_CMD]; // [R2]
  wire [1:0] c_op = cctl_w[`CC_OP_HI:`CC_OP_LO];

  // translation lookup over the four ways
  wire [19:0] t_lin = tctl_w[`TC_LIN_HI:`TC_LIN_LO];
  wire [2:0] t_idx = t_lin[2:0];

  reg [3:0] t_match;
  reg [3:0] t_inval;
  reg [1:0] t_hit_set;
  reg [1:0] t_free_set;
  reg [4:0] ea;
  integer s;

  always @* begin
    t_match = 4'h0;
    t_inval = 4'h0;
    t_hit_set = 2'h0;
    t_free_set = 2'h0;
    ea = 5'h00;

    // ways scanned downward so the lowest matching or empty way wins
    for (s = 3; s >= 0; s = s - 1) begin
      ea = {s[1:0], t_idx};

      t_inval[s] = ~tlb_valid_r[ea];

      t_match[s] = tlb_valid_r[ea] &&
        tlb_lin[ea] == t_lin &&
        attr_ok(tctl_w[`TC_D:`TC_DN], tlb_attr[ea][4]) &&
        attr_ok(tctl_w[`TC_U:`TC_UN], tlb_attr[ea][3]) &&
        attr_ok(tctl_w[`TC_W:`TC_WN], tlb_attr[ea][2]); // [R7]

      if (t_match[s]) begin
        t_hit_set = s[1:0];
      end

      if (t_inval[s]) begin
        t_free_set = s[1:0];
      end
    end
  end

  // a multiple match counts as a miss, nothing is reported from it
  // x & (x - 1) clears the lowest set bit: zero left means one match
  wire t_one = t_match != 4'h0 && (t_match & (t_match - 4'h1)) == 4'h0;
  wire [4:0] t_hit_ea = {t_hit_set, t_idx};
  wire [2:0] t_lru_old = tlb_lru[t_idx];
  // write target: forced set, else an empty way, else pseudo-LRU [R12]
  wire [1:0] t_wset = tdat_w[`TD_HIT] ? tdat_w[`TD_SET_HI:`TD_SET_LO] :
    (t_inval != 4'h0) ? t_free_set : plru_victim(t_lru_old);
  wire [4:0] t_wea = {t_wset, t_idx};

  // cache entry address [R20] [R21]
  // direct-mapped: bit 9 from tag-status on writes, control bit 2 on reads
  wire c_bit9 = two_way_r ? cctl_w[`CC_SET] :
    (c_op == `COP_WRITE) ? cts_w[`TS_TAG_LO] : cctl_w[`CC_SET];
  wire [6:0] c_idx = cctl_w[`CC_IDX_HI:`CC_IDX_LO];
  wire [7:0] c_ea = {c_bit9, c_idx};

  wire [3:0] c_newval = cts_w[`TS_VAL_HI:`TS_VAL_LO];

  // read mux over the registers as they stood before this edge
  always @* begin
    case (ADR_I)
      `IDX_TLB_CTL: rd_nxt = tlb_ctl_r;
      `IDX_TLB_DAT: rd_nxt = tlb_dat_r;
      `IDX_C_DAT: rd_nxt = c_dat_r;
      `IDX_C_TS: rd_nxt = c_ts_r;
      `IDX_C_CTL: rd_nxt = c_ctl_r;
      `IDX_CFG: rd_nxt = {31'h00000000, two_way_r};
      // unmapped words read as zero
      default: rd_nxt = `RST_REG;
    endcase
  end

  // bus answer and software-visible registers
  always @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ack_r <= 1'b0;
      DAT_O <= `RST_REG;

      tlb_ctl_r <= `RST_REG;
      tlb_dat_r <= `RST_REG;

      c_dat_r <= `RST_REG;
      c_ts_r <= `RST_REG;
      c_ctl_r <= `RST_REG;

      two_way_r <= 1'b0;
    end else begin
      // one answer per request, never a wait state
      ack_r <= req;

      // read data holds until the next read is taken
      if (req && !WE_I) begin
        DAT_O <= rd_nxt;
      end

      // plain register writes, byte lanes merged
      tlb_ctl_r <= tctl_w;
      tlb_dat_r <= tdat_w;

      c_dat_r <= cdat_w;
      c_ts_r <= cts_w;
      c_ctl_r <= cctl_w;

      if (wr && ADR_I == `IDX_CFG && SEL_I[0]) begin
        two_way_r <= DAT_I[`CFG_TWO_WAY];
      end

      // lookup results override the plain write of the same edge
      if (tlb_go && tlb_lookup) begin
        tlb_dat_r[`TD_HIT] <= t_one; // [R11]
        tlb_dat_r[`TD_LRU_HI:`TD_LRU_LO] <= t_lru_old; // [R10]

        // a miss leaves the remaining fields as software wrote them
        if (t_one) begin // [R4]
          tlb_ctl_r[`TC_VALID] <= 1'b1;

          tlb_ctl_r[`TC_D] <= tlb_attr[t_hit_ea][4];
          tlb_ctl_r[`TC_DN] <= ~tlb_attr[t_hit_ea][4];

          tlb_ctl_r[`TC_U] <= tlb_attr[t_hit_ea][3];
          tlb_ctl_r[`TC_UN] <= ~tlb_attr[t_hit_ea][3];

          tlb_ctl_r[`TC_W] <= tlb_attr[t_hit_ea][2];
          tlb_ctl_r[`TC_WN] <= ~tlb_attr[t_hit_ea][2];

          tlb_dat_r[31:12] <= tlb_phys[t_hit_ea];
          tlb_dat_r[`TD_PCD] <= tlb_attr[t_hit_ea][1]; // [R9]
          tlb_dat_r[`TD_PWT] <= tlb_attr[t_hit_ea][0]; // [R9]
          tlb_dat_r[`TD_SET_HI:`TD_SET_LO] <= t_hit_set; // [R13]
        end
      end

      // cache read loads the data and tag-status fields
      if (c_go && c_op == `COP_READ) begin // [R18]
        c_dat_r <= c_data[c_ea];
        c_ts_r[`TS_TAG_HI:`TS_TAG_LO] <= c_tag[c_ea]; // [R19]
        c_ts_r[`TS_LRU] <= c_lru_r[c_idx]; // [R16]
        c_ts_r[`TS_VAL_HI:`TS_VAL_LO] <= c_val[c_ea]; // [R15]
      end
    end
  end

  // translation state with reset: valid bits and LRU trees
  always @(posedge CLK_I) begin
    if (!RESETN_I) begin
      tlb_valid_r <= 32'h00000000;
      for (i = 0; i < 8; i = i + 1) begin
        tlb_lru[i] <= `RST_PLRU;
      end
    end else if (tlb_go) begin
      if (!tlb_lookup) begin
        // the chosen way becomes most recently used
        tlb_valid_r[t_wea] <= tctl_w[`TC_VALID]; // [R5]
        tlb_lru[t_idx] <= plru_upd(t_lru_old, t_wset); // [R12]
      end else if (t_one) begin
        // a multiple match leaves the tree untouched
        tlb_lru[t_idx] <= plru_upd(t_lru_old, t_hit_set);
      end
    end
  end

  // translation entry contents; pairs 00 and 11 store the bit as given
  always @(posedge CLK_I) begin
    if (tlb_go && !tlb_lookup) begin
      tlb_lin[t_wea] <= t_lin; // [R3]
      tlb_phys[t_wea] <= tdat_w[31:12]; // [R3]
      tlb_attr[t_wea] <= {tctl_w[`TC_D], tctl_w[`TC_U],
        tctl_w[`TC_W], tdat_w[`TD_PCD], tdat_w[`TD_PWT]}; // [R6] [R8]
    end
  end

  // cache valid bits and LRU; a flush clears every line at once
  always @(posedge CLK_I) begin
    if (!RESETN_I) begin
      c_lru_r <= 128'h0;
      for (i = 0; i < 256; i = i + 1) begin
        c_val[i] <= 4'h0;
      end
    end else if (c_go) begin
      case (c_op)
        `COP_FLUSH: begin // [R22]
          // tag and data are left as they were
          for (i = 0; i < 256; i = i + 1) begin
            c_val[i] <= 4'h0;
          end
        end

        `COP_WRITE: begin
          c_val[c_ea] <= c_newval; // [R15]
          if (two_way_r) begin
            c_lru_r[c_idx] <= cctl_w[`CC_SET]; // [R16]
          end
        end

        `COP_READ: begin
          if (two_way_r) begin
            c_lru_r[c_idx] <= cctl_w[`CC_SET]; // [R16]
          end
        end

        default: begin
        end
      endcase
    end
  end

  // cache tag and data; only bytes marked valid take new data [R17]
  always @(posedge CLK_I) begin
    if (c_go && c_op == `COP_WRITE) begin
      c_tag[c_ea] <= cts_w[`TS_TAG_HI:`TS_TAG_LO]; // [R19]

      // a byte whose new valid bit is clear keeps its old data
      for (i = 0; i < 4; i = i + 1) begin
        if (c_newval[i]) begin
          c_data[c_ea][i*8 +: 8] <= cdat_w[i*8 +: 8]; // [R18]
        end
      end
    end
  end

endmodule // tlb_cache_test_access
`default_nettype wire

/* File: rtl/tlb_cache_consts.vh */
`ifndef TLB_CACHE_CONSTS_VH
`define TLB_CACHE_CONSTS_VH
// word indices on the bus (byte address = index * 4)
`define IDX_TLB_CTL 6'h00
`define IDX_TLB_DAT 6'h01
`define IDX_C_DAT 6'h02
`define IDX_C_TS 6'h03
`define IDX_C_CTL 6'h04
`define IDX_CFG 6'h05
// translation test control fields
`define TC_LIN_HI 31
`define TC_LIN_LO 12
`define TC_VALID 11
`define TC_D 10
`define TC_DN 9
`define TC_U 8
`define TC_UN 7
`define TC_W 6
`define TC_WN 5
`define TC_CMD 0
// translation test data fields
`define TD_PCD 11
`define TD_PWT 10
`define TD_LRU_HI 9
`define TD_LRU_LO 7
`define TD_HIT 4
`define TD_SET_HI 3
`define TD_SET_LO 2
// cache tag-status fields
`define TS_TAG_HI 31
`define TS_TAG_LO 9
`define TS_LRU 7
`define TS_VAL_HI 6
`define TS_VAL_LO 3
// cache control fields
`define CC_IDX_HI 10
`define CC_IDX_LO 4
`define CC_SET 2
`define CC_OP_HI 1
`define CC_OP_LO 0
// cache control commands
`define COP_NONE 2'h0
`define COP_WRITE 2'h1
`define COP_READ 2'h2
`define COP_FLUSH 2'h3
// configuration register: bit 0 selects two-way cache
`define CFG_TWO_WAY 0
// reset values
`define RST_REG 32'h00000000
`define RST_PLRU 3'h0
`endif

/* File: verif/tlb_cache_properties.sv */
`default_nettype none
module tlb_cache_checker (
  // clock and reset
  input wire CLK_I,
  input wire RESETN_I,
  // wishbone
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:2] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  input wire ACK_O,
  input wire [31:0] DAT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] tc_r;
  logic [31:0] cc_r;
  logic cfg_r;
  wire tk = CYC_I & STB_I & ~ACK_O;
  wire rd = tk & ~WE_I;
  wire [31:0] m = {{8{SEL_I[3]}}, {8{SEL_I[2]}},
                   {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  // shadows of fields that no test operation rewrites
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      tc_r <= 32'h0;
      cc_r <= 32'h0;
      cfg_r <= 1'b0;
    end else if (tk && WE_I) begin
      if (ADR_I == 6'h00) tc_r <= (tc_r & ~m) | (DAT_I & m);
      if (ADR_I == 6'h04) cc_r <= (cc_r & ~m) | (DAT_I & m);
      if (ADR_I == 6'h05 && SEL_I[0]) cfg_r <= DAT_I[0];
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  ack_after_req_a: assert property (tk |=> ACK_O)
    else $error("no ack");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  no_stray_ack_a: assert property (!(CYC_I && STB_I) |=> !ACK_O)
    else $error("stray ack");
  dat_hold_a: assert property (!rd |=> $stable(DAT_O))
    else $error("read data moved");
  unmapped_zero_a: assert property (
    rd && ADR_I > 6'h05 |=> DAT_O == 32'h0)
    else $error("unmapped read not zero");
  cctl_back_a: assert property (
    rd && ADR_I == 6'h04 |=> DAT_O == cc_r)
    else $error("cache control readback");
  page_keep_a: assert property (rd && ADR_I == 6'h00 |=>
    DAT_O[31:12] == tc_r[31:12] && DAT_O[0] == tc_r[0])
    else $error("page or command lost");
  cfg_back_a: assert property (
    rd && ADR_I == 6'h05 |=> DAT_O[0] == cfg_r)
    else $error("config readback");
  cover property (tk && WE_I && ADR_I == 6'h00);
  cover property (rd && ADR_I == 6'h01);
  cover property (tk && WE_I && ADR_I == 6'h04);
endmodule // tlb_cache_checker
bind tlb_cache_test_access tlb_cache_checker u_tlb_cache_checker (
  .CLK_I(CLK_I),
  .RESETN_I(RESETN_I),
  .CYC_I(CYC_I),
  .STB_I(STB_I),
  .WE_I(WE_I),
  .ADR_I(ADR_I),
  .SEL_I(SEL_I),
  .DAT_I(DAT_I),
  .ACK_O(ACK_O),
  .DAT_O(DAT_O)
);
`default_nettype wire

/* File: verif/tlb_cache_test_access_tb_top.sv */
`default_nettype none
module tlb_cache_test_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I, RESETN_I, CYC_I, STB_I, WE_I, ACK_O;
  logic [5:0] ADR_I;
  logic [3:0] SEL_I;
  logic [31:0] DAT_I, DAT_O;
  int fail_count = 0;
  int total_checks = 0;
  tlb_cache_test_access u_tlb_cache_test_access (
    .CLK_I(CLK_I),
    .RESETN_I(RESETN_I),
    .CYC_I(CYC_I),
    .STB_I(STB_I),
    .WE_I(WE_I),
    .ADR_I(ADR_I),
    .SEL_I(SEL_I),
    .DAT_I(DAT_I),
    .ACK_O(ACK_O),
    .DAT_O(DAT_O)
  );
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= a;
    SEL_I <= 4'hf;
    DAT_I <= d;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] k,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & k, e);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd(6'(i), 32'hffffffff, 32'h0);
  endtask
  task automatic t_tlb_hit;
    wr(6'h01, 32'habcde818);
    wr(6'h00, 32'h12345cc0);
    wr(6'h01, 32'h0);
    wr(6'h00, 32'h123457e1);
    rd(6'h01, 32'hffffffff, 32'habcdea18);
    rd(6'h00, 32'hffffffff, 32'h12345cc1);
    // same index, flag clear: the lowest empty way takes it
    wr(6'h01, 32'h11111000);
    wr(6'h00, 32'h22345cc0);
    wr(6'h00, 32'h223457e1);
    rd(6'h01, 32'hffffffff, 32'h11111390);
  endtask
  task automatic t_tlb_miss;
    wr(6'h00, 32'h123453e1);
    rd(6'h01, 32'h10, 32'h0);
    wr(6'h00, 32'h123457e1);
    rd(6'h01, 32'h10, 32'h10);
    wr(6'h00, 32'h123451e1);
    rd(6'h01, 32'h10, 32'h0);
    wr(6'h01, 32'h18);
    wr(6'h00, 32'h123454c0);
    wr(6'h00, 32'h123457e1);
    rd(6'h01, 32'h10, 32'h0);
  endtask
  task automatic t_cache;
    wr(6'h05, 32'h1);
    wr(6'h03, 32'h55555678);
    wr(6'h02, 32'hdeadbeef);
    wr(6'h04, 32'h155);
    wr(6'h02, 32'h0);
    wr(6'h03, 32'h0);
    wr(6'h04, 32'h156);
    rd(6'h02, 32'hffffffff, 32'hdeadbeef);
    rd(6'h03, 32'hffffffff, 32'h555556f8);
    wr(6'h04, 32'h152);
    rd(6'h03, 32'h78, 32'h0);
    wr(6'h04, 32'h153);
    wr(6'h04, 32'h156);
    rd(6'h03, 32'h78, 32'h0);
    wr(6'h02, 32'h0);
    wr(6'h04, 32'h154);
    rd(6'h02, 32'hffffffff, 32'h0);
    // direct-mapped: bit 9 of the line comes from tag-status on write
    wr(6'h05, 32'h0);
    wr(6'h03, 32'h278);
    wr(6'h02, 32'hcafef00d);
    wr(6'h04, 32'h151);
    wr(6'h04, 32'h156);
    rd(6'h02, 32'hffffffff, 32'hcafef00d);
    // only byte 0 marked valid: the other bytes keep their data
    wr(6'h03, 32'h208);
    wr(6'h02, 32'h11223344);
    wr(6'h04, 32'h151);
    wr(6'h04, 32'h156);
    rd(6'h02, 32'hffffffff, 32'hcafef044);
    wr(6'h04, 32'h152);
    rd(6'h03, 32'h78, 32'h0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge CLK_I);
    fail_count++;
    final_report();
  end
  initial begin
    {RESETN_I, CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = '0;
    repeat (8) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    t_reset();
    t_tlb_hit();
    t_tlb_miss();
    t_cache();
    final_report();
  end
endmodule // tlb_cache_test_access_tb_top
`default_nettype wire
